// ===== rcsu_top.sv
// remote command and status unit: executes decoded commands in order
`timescale 1ns/100ps
`include "rcsu_defines.svh"
module rcsu_top (
   input wire logic mclk,
   input wire logic arst_n,
   input wire rcsu_pkg::rcsu_cmd_t cmd,
   input wire logic link_parallel,
   input wire rcsu_pkg::rcsu_mode_t meas_mode,
   input wire logic meas_done,
   input wire logic [31:0] meas_res,
   input wire logic [31:0] meas_volt,
   input wire logic test_done,
   input wire logic test_ram_fail,
   input wire logic test_rom_fail,
   input wire logic [7:0] ev_set,
   output logic cmd_ready,
   output rcsu_pkg::rcsu_rsp_t rsp,
   output rcsu_pkg::rcsu_cfg_t cfg,
   output logic [7:0] ev_mask,
   output logic [7:0] ev_status,
   output logic ev_summary,
   output logic meas_start,
   output logic test_start,
   output logic defaults_load,
   output logic display_home,
   output logic status_clear,
   output logic [31:0] ident_version
);
   // arbitrary value, stands for the firmware version string
   localparam logic [31:0] VERSION = `RCSU_VERSION;

   rcsu_pkg::rcsu_state_t state_reg, state_next;
   rcsu_pkg::rcsu_rsp_t rsp_reg, rsp_next;
   rcsu_pkg::rcsu_cfg_t cfg_reg, cfg_next;
   logic [7:0] mask_reg, mask_next;
   logic [7:0] stat_reg, stat_next;
   logic [31:0] last_res_reg, last_res_next;
   logic [31:0] last_volt_reg, last_volt_next;
   logic rdy_reg, rdy_next;
   logic sum_reg, sum_next;
   logic mstart_reg, mstart_next;
   logic tstart_reg, tstart_next;
   logic dflt_reg, dflt_next;
   logic home_reg, home_next;
   logic sclr_reg, sclr_next;
   // version sits in a register so that every output leaves a flip-flop
   logic [31:0] ver_reg, ver_next;
   logic [7:0] ev_in;
   logic stat_wipe;
   logic take;

   // bits that have no meaning on the serial link are forced low
   function automatic logic [7:0] link_bits(input logic [7:0] v,
                                            input logic par);
      link_bits = par ? v : (v & `RCSU_SERIAL_KEEP); // R15
   endfunction

   function automatic rcsu_pkg::rcsu_rsp_t answer(
         input rcsu_pkg::rcsu_rsp_kind_t k,
         input logic [31:0] a,
         input logic [31:0] b);
      rcsu_pkg::rcsu_rsp_t r;
      r.valid = 1'b1;
      r.kind = k;
      r.val_a = a;
      r.val_b = b;
      answer = r;
   endfunction

   function automatic rcsu_pkg::rcsu_rsp_kind_t on_off(input logic v);
      on_off = v ? rcsu_pkg::RCSU_K_ON : rcsu_pkg::RCSU_K_OFF; // R17
   endfunction

   assign take = cmd.valid && rdy_reg;

   always_comb begin
      state_next = state_reg;
      rsp_next = rsp_reg;
      rsp_next.valid = 1'b0;
      cfg_next = cfg_reg;
      mask_next = mask_reg;
      last_res_next = last_res_reg;
      last_volt_next = last_volt_reg;
      mstart_next = 1'b0;
      tstart_next = 1'b0;
      dflt_next = 1'b0;
      home_next = 1'b0;
      sclr_next = 1'b0;
      stat_wipe = 1'b0;
      ev_in = ev_set;
      rdy_next = rdy_reg;
      ver_next = ver_reg;
      if (meas_done) begin
         last_res_next = meas_res; // R21
         last_volt_next = meas_volt;
      end
      case (state_reg)
         rcsu_pkg::RCSU_S_IDLE: begin
            if (take) begin
               case (cmd.code)
                  rcsu_pkg::RCSU_C_IDNQ: begin
                     rsp_next = answer(rcsu_pkg::RCSU_K_IDN,
                                       32'h0000_0000, VERSION); // R1
                  end
                  rcsu_pkg::RCSU_C_RST: begin
                     // link settings live outside this block
                     cfg_next.trig_ext = 1'b0; // R2 R4
                     cfg_next.dly_on = 1'b0;
                     cfg_next.dly_ms = `RCSU_DLY_RST;
                     cfg_next.cont_on = 1'b1;
                     dflt_next = 1'b1; // R2
                     home_next = 1'b1; // R3
                  end
                  rcsu_pkg::RCSU_C_TSTQ: begin
                     tstart_next = 1'b1;
                     rdy_next = 1'b0;
                     state_next = rcsu_pkg::RCSU_S_TEST;
                  end
                  rcsu_pkg::RCSU_C_OPC: begin
                     // commands run strictly in order, so all prior ones
                     // are finished once this one is taken
                     ev_in[`RCSU_BIT_OPC] = 1'b1; // R6
                  end
                  rcsu_pkg::RCSU_C_OPCQ: begin
                     rsp_next = answer(rcsu_pkg::RCSU_K_NR1,
                                       `RCSU_OPC_ANSWER,
                                       32'h0000_0000); // R7
                  end
                  rcsu_pkg::RCSU_C_WAI: begin
                     rdy_next = rdy_reg; // R8
                  end
                  rcsu_pkg::RCSU_C_CLS: begin
                     stat_wipe = 1'b1; // R9
                     sclr_next = 1'b1; // R9 R10
                  end
                  rcsu_pkg::RCSU_C_ESE: begin
                     if (cmd.arg <= `RCSU_ARG_MAX) begin
                        mask_next = cmd.arg[7:0]; // R11
                     end else begin
                        ev_in[`RCSU_BIT_EXE] = 1'b1;
                     end
                  end
                  rcsu_pkg::RCSU_C_ESEQ: begin
                     rsp_next = answer(rcsu_pkg::RCSU_K_NR1,
                                       {24'h000000, mask_reg},
                                       32'h0000_0000); // R13
                  end
                  rcsu_pkg::RCSU_C_ESRQ: begin
                     rsp_next = answer(rcsu_pkg::RCSU_K_NR1,
                                       {24'h000000, stat_reg},
                                       32'h0000_0000); // R14
                     stat_wipe = 1'b1; // R14
                  end
                  rcsu_pkg::RCSU_C_TSRC: begin
                     cfg_next.trig_ext = cmd.arg[0]; // R18
                  end
                  rcsu_pkg::RCSU_C_TSRCQ: begin
                     rsp_next = answer(cfg_reg.trig_ext ?
                                       rcsu_pkg::RCSU_K_EXTERNAL :
                                       rcsu_pkg::RCSU_K_IMMEDIATE,
                                       32'h0000_0000,
                                       32'h0000_0000); // R18 R17
                  end
                  rcsu_pkg::RCSU_C_DLYST: begin
                     cfg_next.dly_on = cmd.arg[0]; // R19
                  end
                  rcsu_pkg::RCSU_C_DLYSTQ: begin
                     rsp_next = answer(on_off(cfg_reg.dly_on),
                                       32'h0000_0000,
                                       32'h0000_0000); // R19
                  end
                  rcsu_pkg::RCSU_C_DLY: begin
                     // the parser turns any numeric form into ms
                     if (cmd.arg <= `RCSU_DLY_MAX) begin
                        cfg_next.dly_ms = cmd.arg; // R19 R16
                     end else begin
                        ev_in[`RCSU_BIT_EXE] = 1'b1;
                     end
                  end
                  rcsu_pkg::RCSU_C_DLYQ: begin
                     rsp_next = answer(rcsu_pkg::RCSU_K_DELAY,
                                       {16'h0000, cfg_reg.dly_ms},
                                       32'h0000_0000); // R19
                  end
                  rcsu_pkg::RCSU_C_CONT: begin
                     cfg_next.cont_on = cmd.arg[0]; // R20
                  end
                  rcsu_pkg::RCSU_C_CONTQ: begin
                     rsp_next = answer(on_off(cfg_reg.cont_on),
                                       32'h0000_0000,
                                       32'h0000_0000); // R20
                  end
                  rcsu_pkg::RCSU_C_FETCHQ: begin
                     rsp_next = answer(rcsu_pkg::RCSU_K_MEAS_RV,
                                       last_res_reg,
                                       last_volt_reg); // R21
                  end
                  rcsu_pkg::RCSU_C_READQ: begin
                     mstart_next = 1'b1; // R22
                     rdy_next = 1'b0;
                     state_next = rcsu_pkg::RCSU_S_MEAS;
                  end
                  default: begin
                     ev_in[`RCSU_BIT_CME] = 1'b1;
                  end
               endcase
            end
         end
         rcsu_pkg::RCSU_S_TEST: begin
            if (test_done) begin
               rsp_next = answer(rcsu_pkg::RCSU_K_NR1,
                                 {30'h0, test_rom_fail,
                                  test_ram_fail},
                                 32'h0000_0000); // R5
               rdy_next = 1'b1;
               state_next = rcsu_pkg::RCSU_S_IDLE;
            end
         end
         rcsu_pkg::RCSU_S_MEAS: begin
            if (meas_done) begin
               case (meas_mode)
                  rcsu_pkg::RCSU_M_RES: begin
                     rsp_next = answer(rcsu_pkg::RCSU_K_MEAS_R,
                                       meas_res, 32'h0000_0000); // R22
                  end
                  rcsu_pkg::RCSU_M_VOLT: begin
                     rsp_next = answer(rcsu_pkg::RCSU_K_MEAS_V,
                                       meas_volt, 32'h0000_0000); // R22
                  end
                  default: begin
                     rsp_next = answer(rcsu_pkg::RCSU_K_MEAS_RV,
                                       meas_res, meas_volt); // R22
                  end
               endcase
               rdy_next = 1'b1;
               state_next = rcsu_pkg::RCSU_S_IDLE;
            end
         end
         default: begin
            rdy_next = 1'b1;
            state_next = rcsu_pkg::RCSU_S_IDLE;
         end
      endcase
      // an event in the clearing cycle survives the clear
      stat_next = link_bits((stat_wipe ? 8'h00 : stat_reg) | ev_in,
                            link_parallel); // R23 R15
      sum_next = |(stat_next & mask_next);
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= rcsu_pkg::RCSU_S_IDLE;
         rsp_reg <= '0;
         cfg_reg <= '{trig_ext: 1'b0, dly_on: 1'b0,
                      dly_ms: `RCSU_DLY_RST, cont_on: 1'b1};
         mask_reg <= `RCSU_MASK_RST; // R12
         stat_reg <= `RCSU_STAT_RST;
         last_res_reg <= 32'h0000_0000;
         last_volt_reg <= 32'h0000_0000;
         rdy_reg <= 1'b1;
         sum_reg <= 1'b0;
         mstart_reg <= 1'b0;
         tstart_reg <= 1'b0;
         dflt_reg <= 1'b0;
         home_reg <= 1'b0;
         sclr_reg <= 1'b0;
         ver_reg <= VERSION;
      end else begin
         state_reg <= state_next;
         rsp_reg <= rsp_next;
         cfg_reg <= cfg_next;
         mask_reg <= mask_next;
         stat_reg <= stat_next;
         last_res_reg <= last_res_next;
         last_volt_reg <= last_volt_next;
         rdy_reg <= rdy_next;
         sum_reg <= sum_next;
         mstart_reg <= mstart_next;
         tstart_reg <= tstart_next;
         dflt_reg <= dflt_next;
         home_reg <= home_next;
         sclr_reg <= sclr_next;
         ver_reg <= ver_next;
      end
   end

   assign cmd_ready = rdy_reg;
   assign rsp = rsp_reg;
   assign cfg = cfg_reg;
   assign ev_mask = mask_reg;
   assign ev_status = stat_reg;
   assign ev_summary = sum_reg;
   assign meas_start = mstart_reg;
   assign test_start = tstart_reg;
   assign defaults_load = dflt_reg;
   assign display_home = home_reg;
   assign status_clear = sclr_reg;
   assign ident_version = ver_reg;
endmodule

// ===== rcsu_defines.svh
// constants of the remote command and status unit
// What this block does
// (R1) identity query answers maker, model, zero field and software version
// (R2) reset restores factory settings and leaves saved setting data alone
// (R3) after reset the front panel returns to its initial display
// (R4) reset leaves the link configuration untouched
// (R5) self-test reports 0 none, 1 volatile, 2 nonvolatile, 3 both faults
// (R6) on the parallel link, operation-complete command sets status bit 0 once prior commands finish
// (R7) operation-complete query answers 1 once prior commands finish
// (R8) wait command is accepted and does nothing
// (R9) clear-status clears event registers and the status byte
// (R10) clear-status spares output queue; on parallel bus spares enables, bit 4
// (R11) event-enable command loads the mask with 0 to 255
// (R12) event-enable mask is zero after power-on
// (R13) event-enable query returns the mask last written
// (R14) event-status query returns the register headerless, then clears it
// (R15) on the serial link bits 6, 1 and 0 read as zero
// (R16) numeric parameters may be integer, fixed-point or exponential
// (R17) character parameters are returned in upper case only
// (R18) trigger source is immediate or external and can be read back
// (R19) trigger delay switches on or off; time 0 to 9.999 s, readable
// (R20) continuous measurement switches on or off and can be read back
// (R21) fetch returns the last finished measurement without measuring
// (R22) read measures, returns both, resistance or voltage by mode
// (R23) status bits stay set until read by status query or clear-status
`ifndef RCSU_DEFINES_SVH
`define RCSU_DEFINES_SVH
`define RCSU_MASK_RST 8'h00
`define RCSU_STAT_RST 8'h80
`define RCSU_BIT_PON 7
`define RCSU_BIT_URQ 6
`define RCSU_BIT_CME 5
`define RCSU_BIT_EXE 4
`define RCSU_BIT_DDE 3
`define RCSU_BIT_QYE 2
`define RCSU_BIT_RQC 1
`define RCSU_BIT_OPC 0
`define RCSU_SERIAL_KEEP 8'hBC
`define RCSU_ARG_MAX 16'h00FF
`define RCSU_DLY_MAX 16'h270F
`define RCSU_DLY_RST 16'h0000
`define RCSU_OPC_ANSWER 32'h0000_0001
`define RCSU_VERSION 32'h0000_0100
`endif

// ===== rcsu_pkg.sv
// types of the remote command and status unit
package rcsu_pkg;
   typedef enum logic [4:0] {
      RCSU_C_IDNQ = 5'h00, RCSU_C_RST = 5'h01, RCSU_C_TSTQ = 5'h02,
      RCSU_C_OPC = 5'h03, RCSU_C_OPCQ = 5'h04, RCSU_C_WAI = 5'h05,
      RCSU_C_CLS = 5'h06, RCSU_C_ESE = 5'h07, RCSU_C_ESEQ = 5'h08,
      RCSU_C_ESRQ = 5'h09, RCSU_C_TSRC = 5'h0A, RCSU_C_TSRCQ = 5'h0B,
      RCSU_C_DLYST = 5'h0C, RCSU_C_DLYSTQ = 5'h0D, RCSU_C_DLY = 5'h0E,
      RCSU_C_DLYQ = 5'h0F, RCSU_C_CONT = 5'h10, RCSU_C_CONTQ = 5'h11,
      RCSU_C_FETCHQ = 5'h12, RCSU_C_READQ = 5'h13
   } rcsu_cmd_code_t;
   // character answers are codes for upper-case words only
   typedef enum logic [3:0] {
      RCSU_K_NONE = 4'h0, RCSU_K_NR1 = 4'h1, RCSU_K_IDN = 4'h2,
      RCSU_K_IMMEDIATE = 4'h3, RCSU_K_EXTERNAL = 4'h4, RCSU_K_ON = 4'h5,
      RCSU_K_OFF = 4'h6, RCSU_K_DELAY = 4'h7, RCSU_K_MEAS_RV = 4'h8,
      RCSU_K_MEAS_R = 4'h9, RCSU_K_MEAS_V = 4'hA
   } rcsu_rsp_kind_t;
   typedef enum logic [1:0] {
      RCSU_M_RV = 2'h0, RCSU_M_RES = 2'h1, RCSU_M_VOLT = 2'h2
   } rcsu_mode_t;
   typedef enum logic [1:0] {
      RCSU_S_IDLE = 2'h0, RCSU_S_TEST = 2'h1, RCSU_S_MEAS = 2'h2
   } rcsu_state_t;
   typedef struct packed {
      logic valid;
      rcsu_cmd_code_t code;
      logic [15:0] arg;
   } rcsu_cmd_t;
   typedef struct packed {
      logic valid;
      rcsu_rsp_kind_t kind;
      logic [31:0] val_a;
      logic [31:0] val_b;
   } rcsu_rsp_t;
   typedef struct packed {
      logic trig_ext;
      logic dly_on;
      logic [15:0] dly_ms;
      logic cont_on;
   } rcsu_cfg_t;
endpackage

// ===== rcsu_top_assertions.sv
// concurrent checks on the ports of the command and status unit
`timescale 1ns/100ps
module rcsu_top_checker (
   input wire logic mclk,
   input wire logic arst_n,
   input wire rcsu_pkg::rcsu_cmd_t cmd,
   input wire logic link_parallel,
   input wire logic test_done,
   input wire logic test_ram_fail,
   input wire logic test_rom_fail,
   input wire logic [7:0] ev_set,
   input wire logic cmd_ready,
   input wire rcsu_pkg::rcsu_rsp_t rsp,
   input wire logic [7:0] ev_mask,
   input wire logic [7:0] ev_status,
   input wire logic meas_start,
   input wire logic test_start,
   input wire logic status_clear
);
   logic tk;
   logic calm;
   assign tk = cmd.valid && cmd_ready;
   assign calm = ev_set == 8'h00;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_esr_read: assert property (
      tk && calm && cmd.code == rcsu_pkg::RCSU_C_ESRQ
      |=> rsp.valid && rsp.val_a == {24'h0, $past(ev_status)}
      && ev_status == 8'h00) else $error("status query answer");
   a_mask_load: assert property (
      tk && cmd.code == rcsu_pkg::RCSU_C_ESE && cmd.arg <= 16'h00FF
      |=> {8'h00, ev_mask} == $past(cmd.arg))
      else $error("mask not loaded");
   a_mask_range: assert property (
      tk && cmd.code == rcsu_pkg::RCSU_C_ESE && cmd.arg > 16'h00FF
      |=> $stable(ev_mask) && ev_status[4])
      else $error("bad mask accepted");
   a_serial_zero: assert property (
      !link_parallel && !$past(link_parallel)
      |-> (ev_status & 8'h43) == 8'h00) else $error("serial bits set");
   a_opc_query: assert property (
      tk && cmd.code == rcsu_pkg::RCSU_C_OPCQ
      |=> rsp.valid && rsp.val_a == 32'h1) else $error("opc query");
   a_opc_bit: assert property (
      tk && cmd.code == rcsu_pkg::RCSU_C_OPC && link_parallel
      |=> ev_status[0]) else $error("opc bit clear");
   a_cls_clear: assert property (
      tk && calm && cmd.code == rcsu_pkg::RCSU_C_CLS
      |=> ev_status == 8'h00 && status_clear && $stable(ev_mask))
      else $error("clear status");
   a_wait_none: assert property (
      tk && calm && cmd.code == rcsu_pkg::RCSU_C_WAI && link_parallel
      |=> $stable(ev_status)) else $error("wait changed status");
   a_bit_sticky: assert property (
      ev_status[5] && !(tk && (cmd.code == rcsu_pkg::RCSU_C_ESRQ
      || cmd.code == rcsu_pkg::RCSU_C_CLS))
      |=> ev_status[5]) else $error("status bit lost");
   a_test_code: assert property (
      test_done && !cmd_ready |=> rsp.valid
      && rsp.val_a == {30'h0, $past(test_rom_fail), $past(test_ram_fail)})
      else $error("self-test code");
   a_test_start: assert property (
      tk && cmd.code == rcsu_pkg::RCSU_C_TSTQ
      |=> test_start && !cmd_ready) else $error("test not started");
   a_read_start: assert property (
      tk && cmd.code == rcsu_pkg::RCSU_C_READQ
      |=> meas_start && !cmd_ready) else $error("read not started");
   a_fetch_only: assert property (
      tk && cmd.code == rcsu_pkg::RCSU_C_FETCHQ
      |=> rsp.valid && !meas_start) else $error("fetch measured");
endmodule
bind rcsu_top rcsu_top_checker rcsu_top_checker_i (.mclk(mclk),
   .arst_n(arst_n), .cmd(cmd), .link_parallel(link_parallel),
   .test_done(test_done), .test_ram_fail(test_ram_fail),
   .test_rom_fail(test_rom_fail), .ev_set(ev_set), .cmd_ready(cmd_ready),
   .rsp(rsp), .ev_mask(ev_mask), .ev_status(ev_status),
   .meas_start(meas_start), .test_start(test_start),
   .status_clear(status_clear));

// ===== rcsu_meas_model.sv
// measuring core and self-test engine facing the unit
`timescale 1ns/100ps
module rcsu_meas_model (
   input wire logic mclk,
   input wire logic meas_start,
   input wire logic test_start,
   input wire logic [1:0] fault,
   input wire logic [3:0] lat,
   input wire logic [31:0] res_in,
   input wire logic [31:0] volt_in,
   output logic meas_done = 1'b0,
   output logic [31:0] meas_res = 32'h0,
   output logic [31:0] meas_volt = 32'h0,
   output logic test_done = 1'b0,
   output logic test_ram_fail = 1'b0,
   output logic test_rom_fail = 1'b0
);
   logic [4:0] cnt = 5'h00;
   logic is_test = 1'b0;
   // results only mean something with their done pulse, so they wander
   always @(posedge mclk) begin
      meas_done <= 1'b0;
      test_done <= 1'b0;
      meas_res <= ~meas_res;
      meas_volt <= ~meas_volt;
      {test_rom_fail, test_ram_fail} <= ~{test_rom_fail, test_ram_fail};
      if (meas_start || test_start) begin
         cnt <= {1'b0, lat} + 5'h01;
         is_test <= test_start;
      end else if (cnt > 5'h01) begin
         cnt <= cnt - 5'h01;
      end else if (cnt == 5'h01) begin
         cnt <= 5'h00;
         if (is_test) begin
            test_done <= 1'b1;
            {test_rom_fail, test_ram_fail} <= fault;
         end else begin
            meas_done <= 1'b1;
            meas_res <= res_in;
            meas_volt <= volt_in;
         end
      end
   end
endmodule

// ===== tb_top.sv
// self-checking bench for the command and status unit
`timescale 1ns/100ps
`include "rcsu_defines.svh"
module tb_top;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   rcsu_pkg::rcsu_cmd_t cmd = '0;
   logic link_parallel = 1'b1;
   rcsu_pkg::rcsu_mode_t meas_mode = rcsu_pkg::RCSU_M_RV;
   logic [7:0] ev_set = 8'h00;
   logic [1:0] fault = 2'h0;
   logic [3:0] lat = 4'h2;
   logic [31:0] res_in = 32'h0;
   logic [31:0] volt_in = 32'h0;
   logic meas_done, test_done, test_ram_fail, test_rom_fail, cmd_ready;
   logic ev_summary, meas_start, test_start, defaults_load, display_home;
   logic status_clear;
   logic [31:0] meas_res, meas_volt, ident_version;
   logic [7:0] ev_mask, ev_status;
   rcsu_pkg::rcsu_rsp_t rsp;
   rcsu_pkg::rcsu_cfg_t cfg;
   logic [15:0] ese_v [3] = '{16'h0000, 16'h0024, 16'h00FF};
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   always #2 mclk = ~mclk;
   rcsu_top rcsu_top_i (.mclk(mclk), .arst_n(arst_n), .cmd(cmd),
      .link_parallel(link_parallel), .meas_mode(meas_mode),
      .meas_done(meas_done), .meas_res(meas_res), .meas_volt(meas_volt),
      .test_done(test_done), .test_ram_fail(test_ram_fail),
      .test_rom_fail(test_rom_fail), .ev_set(ev_set), .cmd_ready(cmd_ready),
      .rsp(rsp), .cfg(cfg), .ev_mask(ev_mask), .ev_status(ev_status),
      .ev_summary(ev_summary), .meas_start(meas_start),
      .test_start(test_start), .defaults_load(defaults_load),
      .display_home(display_home), .status_clear(status_clear),
      .ident_version(ident_version));
   rcsu_meas_model rcsu_meas_model_i (.mclk(mclk), .meas_start(meas_start),
      .test_start(test_start), .fault(fault), .lat(lat), .res_in(res_in),
      .volt_in(volt_in), .meas_done(meas_done), .meas_res(meas_res),
      .meas_volt(meas_volt), .test_done(test_done),
      .test_ram_fail(test_ram_fail), .test_rom_fail(test_rom_fail));
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // returns one step after the edge that brings the answer
   task automatic send(input rcsu_pkg::rcsu_cmd_code_t c,
         input logic [15:0] a);
      int n;
      n = 0;
      @(posedge mclk);
      #1;
      cmd = {1'b1, c, a};
      while (cmd_ready !== 1'b1 && n < 99) begin
         @(posedge mclk);
         #1;
         n++;
      end
      @(posedge mclk);
      #1;
      cmd.valid = 1'b0;
      if (c == rcsu_pkg::RCSU_C_TSTQ || c == rcsu_pkg::RCSU_C_READQ) begin
         while (rsp.valid !== 1'b1 && n < 99) begin
            @(posedge mclk);
            #1;
            n++;
         end
      end
   endtask
   task automatic q(input rcsu_pkg::rcsu_cmd_code_t c, input logic [31:0] e);
      send(c, 16'h0000);
      chk(32'(rsp.valid), 32'h1);
      chk(rsp.val_a, e);
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      repeat (16) @(posedge mclk);
      #1;
      arst_n = 1'b1;
      chk(32'(ev_mask), 32'h0);
      send(rcsu_pkg::RCSU_C_IDNQ, 16'h0000);
      chk(32'(rsp.kind), 32'(rcsu_pkg::RCSU_K_IDN));
      chk(rsp.val_a, 32'h0);
      chk(rsp.val_b, `RCSU_VERSION);
      chk(ident_version, `RCSU_VERSION);
      q(rcsu_pkg::RCSU_C_ESRQ, 32'h80);
      chk(32'(ev_status), 32'h0);
      for (int i = 0; i < 3; i++) begin
         send(rcsu_pkg::RCSU_C_ESE, ese_v[i]);
         q(rcsu_pkg::RCSU_C_ESEQ, 32'(ese_v[i]));
      end
      send(rcsu_pkg::RCSU_C_ESE, 16'h0100);
      chk(32'(ev_mask), 32'hFF);
      chk(32'(ev_summary), 32'h1);
      q(rcsu_pkg::RCSU_C_ESRQ, 32'h10);
      send(rcsu_pkg::rcsu_cmd_code_t'(5'h1F), 16'h0000);
      repeat (3) @(posedge mclk);
      #1;
      chk(32'(ev_status), 32'h20);
      send(rcsu_pkg::RCSU_C_CLS, 16'h0000);
      chk(32'({ev_status, status_clear}), 32'h1);
      chk(32'(ev_mask), 32'hFF);
      send(rcsu_pkg::RCSU_C_OPC, 16'h0000);
      send(rcsu_pkg::RCSU_C_WAI, 16'h0000);
      chk(32'(ev_status), 32'h01);
      q(rcsu_pkg::RCSU_C_OPCQ, 32'h1);
      q(rcsu_pkg::RCSU_C_ESRQ, 32'h1);
      link_parallel = 1'b0;
      ev_set = 8'hFF;
      @(posedge mclk);
      #1;
      ev_set = 8'h00;
      send(rcsu_pkg::RCSU_C_OPC, 16'h0000);
      q(rcsu_pkg::RCSU_C_ESRQ, 32'hBC);
      link_parallel = 1'b1;
      for (int f = 0; f < 4; f++) begin
         fault = 2'(f);
         lat = 4'(5 * f);
         q(rcsu_pkg::RCSU_C_TSTQ, 32'(f));
      end
      send(rcsu_pkg::RCSU_C_TSRC, 16'h0001);
      send(rcsu_pkg::RCSU_C_TSRCQ, 16'h0000);
      chk(32'(rsp.kind), 32'(rcsu_pkg::RCSU_K_EXTERNAL));
      send(rcsu_pkg::RCSU_C_DLYST, 16'h0001);
      send(rcsu_pkg::RCSU_C_DLYSTQ, 16'h0000);
      chk(32'(rsp.kind), 32'(rcsu_pkg::RCSU_K_ON));
      send(rcsu_pkg::RCSU_C_DLY, 16'h270F);
      send(rcsu_pkg::RCSU_C_DLY, 16'h2710);
      q(rcsu_pkg::RCSU_C_DLYQ, 32'h270F);
      chk(32'(ev_status[4]), 32'h1);
      send(rcsu_pkg::RCSU_C_CONT, 16'h0000);
      send(rcsu_pkg::RCSU_C_CONTQ, 16'h0000);
      chk(32'(rsp.kind), 32'(rcsu_pkg::RCSU_K_OFF));
      chk(32'(cfg), 32'h0006_4E1E);
      send(rcsu_pkg::RCSU_C_RST, 16'h0000);
      chk(32'({defaults_load, display_home}), 32'h3);
      chk(32'(cfg), 32'h1);
      for (int m = 0; m < 3; m++) begin
         meas_mode = rcsu_pkg::rcsu_mode_t'(m);
         res_in = 32'h100 + 32'(m);
         volt_in = 32'h200 + 32'(m);
         send(rcsu_pkg::RCSU_C_READQ, 16'h0000);
         chk(32'(rsp.kind), 32'(m) + 32'h8);
         // a single-value mode answers in the first slot, the second is zero
         chk(rsp.val_a, (m == 2) ? volt_in : res_in);
         chk(rsp.val_b, (m == 0) ? volt_in : 32'h0);
      end
      res_in = 32'h0;
      send(rcsu_pkg::RCSU_C_FETCHQ, 16'h0000);
      chk({rsp.val_a[15:0], rsp.val_b[15:0]}, 32'h0102_0202);
      stop_test();
   end
endmodule
